// file: rtl/rch_device.sv
// device end of the remote command link: pulse filters and sequencer
// assumes the command pins are asynchronous and the user side is on clk_sys
//
// Summary of operation
// - controller holds each command low 50 ms
// - commands ignored until 1 ms after ready
// - multi-area: 1 ms from select to op
// - multi-area: busy within 100 ms of op
// - multi-area: clear 5 ms after busy falls
// - result lines drop within 50 ms of clear
// - multi-area: select 10 ms after busy falls
// - single-step: 1 ms from advance to op
// - single-step: busy within 8000 ms after area change
// - single-step: busy within 50 ms otherwise
// - single-step: clear 1 ms after busy falls
// - single-step: advance 1 ms after busy falls
module rch_device #(
   parameter int unsigned CYCLES_PER_MS = rch_pkg::CYCLES_PER_MS
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   rch_if.devEnd            lnk,
   input  wire logic        linkEnable,
   input  wire logic        modeSingleStep,
   input  wire logic        opDone,
   input  wire logic        opPass,
   output logic             opStart,
   output rch_pkg::rch_cmd_t opKind,
   output logic [1:0]       opArea,
   output logic             linkArmed
);
   import rch_pkg::*;

   // ---------------------------------------------------------------
   // millisecond timebase
   // ---------------------------------------------------------------
   logic [DIV_W-1:0] divCnt_reg;
   logic             msTick_reg;

   // one-cycle tick every millisecond
   always_ff @(posedge clk_sys) begin
      if (rst || divCnt_reg == DIV_W'(CYCLES_PER_MS - 1)) begin
         divCnt_reg <= '0;
      end else begin
         divCnt_reg <= divCnt_reg + 1'b1;
      end
      msTick_reg <= !rst && divCnt_reg == DIV_W'(CYCLES_PER_MS - 1);
   end

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [7:0] pinN;
   logic [7:0] syncA_reg;
   logic [7:0] syncB_reg;
   logic [7:0] syncC_reg;
   logic [7:0] level_reg;
   logic [7:0] level_next;
   logic [5:0] lowCh;

   assign pinN = {lnk.area_select_in_2, lnk.area_select_in_1, lnk.area_select_in_0,
                  lnk.advanceCmdN, lnk.clearCmdN, lnk.enterCmdN, lnk.startCmdN,
                  lnk.verify_cmd_in};
   // a level moves only once stages two and three agree
   assign level_next = (syncB_reg & syncC_reg) | (level_reg & (syncB_reg ^ syncC_reg));
   // channel 5 is any area-select line held low
   assign lowCh = {~&level_reg[7:5], ~level_reg[4:0]};

   // three flops per pin, then the agreed level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         syncA_reg <= PIN_IDLE;
         syncB_reg <= PIN_IDLE;
         syncC_reg <= PIN_IDLE;
         level_reg <= PIN_IDLE;
      end else begin
         syncA_reg <= pinN;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
         level_reg <= level_next;
      end
   end

   // ---------------------------------------------------------------
   // link arming
   // ---------------------------------------------------------------
   logic       linkReady_reg;
   logic [1:0] armCnt_reg;
   logic       armed;

   // two ticks after the rise guarantee a full millisecond has passed
   assign armed = armCnt_reg == ARM_TICKS;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         linkReady_reg <= 1'b0;
         armCnt_reg    <= '0;
         linkArmed     <= 1'b0;
      end else begin
         linkReady_reg <= linkEnable;
         linkArmed     <= armed;
         if (!linkReady_reg) begin
            armCnt_reg <= '0;
         end else if (msTick_reg && !armed) begin
            armCnt_reg <= armCnt_reg + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // low-width filters
   // ---------------------------------------------------------------
   logic [5:0] widthCnt_reg [6];
   logic [5:0] fire;

   // a pulse fires once, on the tick that completes the accepted width;
   // 49 ticks of a free-running timebase never exceed 49 ms plus sync delay
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 6; i++) begin
         if (rst || !armed || !lowCh[i]) begin
            widthCnt_reg[i] <= '0;
         end else if (msTick_reg && widthCnt_reg[i] != ACCEPT_TICKS) begin
            widthCnt_reg[i] <= widthCnt_reg[i] + 1'b1;
         end
      end
   end

   for (genvar g = 0; g < 6; g++) begin : g_fire
      assign fire[g] = armed && lowCh[g] && msTick_reg &&
                       widthCnt_reg[g] == ACCEPT_TICKS - 6'h1;
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   rch_dev_state_t state_reg;
   rch_dev_state_t state_next;
   logic           accepting;
   logic           opFire;
   logic           selFire;
   logic           advFire;
   logic           clrFire;
   rch_cmd_t       fireKind;
   logic [1:0]     selArea;
   logic [1:0]     curArea_reg;
   logic           areaChanged_reg;
   logic [12:0]    loadCnt_reg;
   logic           loadDone;
   logic           busy_reg;
   logic           pass_reg;
   logic           error_reg;

   // a new command may also cut short a standing result
   assign accepting = state_reg == DS_IDLE || state_reg == DS_RESULT;
   assign opFire    = accepting && |fire[2:0];
   assign selFire   = accepting && fire[5] && !modeSingleStep;
   assign advFire   = accepting && fire[4] && modeSingleStep;
   assign clrFire   = state_reg == DS_RESULT && fire[3];
   assign fireKind  = fire[0] ? RCH_VERIFY : (fire[1] ? RCH_START : RCH_ENTER);
   // lowest low select line wins when more than one is held
   assign selArea   = !level_reg[5] ? 2'h0 : (!level_reg[6] ? 2'h1 : 2'h2);
   assign loadDone  = msTick_reg && loadCnt_reg == AREA_LOAD_TICKS - 13'h1;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // next state; the area reload only happens in single-step mode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DS_IDLE, DS_RESULT: begin
            if (opFire && modeSingleStep && areaChanged_reg) begin
               state_next = DS_LOAD;
            end else if (opFire) begin
               state_next = DS_RUN;
            end else if (clrFire) begin
               state_next = DS_IDLE;
            end
         end
         DS_LOAD: begin
            if (loadDone) begin
               state_next = DS_RUN;
            end
         end
         DS_RUN: begin
            if (opDone) begin
               state_next = DS_RESULT;
            end
         end
         default: begin
            state_next = DS_IDLE;
         end
      endcase
   end

   // state, area bookkeeping and area-load timer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg       <= DS_IDLE;
         curArea_reg     <= '0;
         areaChanged_reg <= 1'b0;
         loadCnt_reg     <= '0;
      end else begin
         state_reg <= state_next;
         if (selFire) begin
            curArea_reg     <= selArea;
            areaChanged_reg <= 1'b1;
         end else if (advFire) begin
            curArea_reg     <= (curArea_reg == AREA_LAST) ? 2'h0 : curArea_reg + 2'h1;
            areaChanged_reg <= 1'b1;
         end else if (opFire) begin
            areaChanged_reg <= 1'b0;
         end
         if (state_reg != DS_LOAD) begin
            loadCnt_reg <= '0;
         end else if (msTick_reg) begin
            loadCnt_reg <= loadCnt_reg + 13'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // answer lines and user strobe
   // ---------------------------------------------------------------
   // busy follows run, result lines stand until clear or a new verify, start or enter command
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_reg  <= 1'b0;
         pass_reg  <= 1'b0;
         error_reg <= 1'b0;
         opStart   <= 1'b0;
         opKind    <= RCH_VERIFY;
         opArea    <= '0;
      end else begin
         busy_reg <= state_next == DS_RUN;
         opStart  <= state_reg != DS_RUN && state_next == DS_RUN;
         if (opFire) begin
            opKind <= fireKind;
            opArea <= selFire ? selArea : curArea_reg;
         end
         if (state_reg == DS_RUN && opDone) begin
            pass_reg  <= opPass;
            error_reg <= !opPass;
         end else if (clrFire || opFire) begin
            pass_reg  <= 1'b0;
            error_reg <= 1'b0;
         end
      end
   end

   assign lnk.link_ready_out = linkReady_reg;
   assign lnk.busyOut        = busy_reg;
   assign lnk.passOut        = pass_reg;
   assign lnk.errorOut       = error_reg;

endmodule

// file: rtl/rch_host.sv
// controller end of the remote command link: paced pulse generator
// assumes the device answer lines are asynchronous to clk_sys
module rch_host #(
   parameter int unsigned CYCLES_PER_MS = rch_pkg::CYCLES_PER_MS
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   rch_if.hostEnd                 lnk,
   input  wire logic              cmdValid,
   input  wire rch_pkg::rch_cmd_t cmdKind,
   input  wire logic [1:0]        cmdArea,
   input  wire logic              modeSingleStep,
   output logic                   cmdReady,
   output logic                   linkSeen,
   output logic                   busySeen,
   output logic                   passSeen,
   output logic                   errorSeen
);
   import rch_pkg::*;

   // ---------------------------------------------------------------
   // timebase and answer synchronisers
   // ---------------------------------------------------------------
   logic [DIV_W-1:0] divCnt_reg;
   logic             msTick_reg;
   logic [3:0]       syncA_reg;
   logic [3:0]       syncB_reg;
   logic [3:0]       syncC_reg;
   logic [3:0]       level_reg;
   logic [3:0]       level_next;

   assign level_next = (syncB_reg & syncC_reg) | (level_reg & (syncB_reg ^ syncC_reg));

   // tick divider and three-flop capture of link, busy, pass, error
   always_ff @(posedge clk_sys) begin
      if (rst || divCnt_reg == DIV_W'(CYCLES_PER_MS - 1)) begin
         divCnt_reg <= '0;
      end else begin
         divCnt_reg <= divCnt_reg + 1'b1;
      end
      msTick_reg <= !rst && divCnt_reg == DIV_W'(CYCLES_PER_MS - 1);
      if (rst) begin
         syncA_reg <= HOST_IN_RST;
         syncB_reg <= HOST_IN_RST;
         syncC_reg <= HOST_IN_RST;
         level_reg <= HOST_IN_RST;
      end else begin
         syncA_reg <= {lnk.errorOut, lnk.passOut, lnk.busyOut, lnk.link_ready_out};
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
         level_reg <= level_next;
      end
   end

   // ---------------------------------------------------------------
   // spacing counters
   // ---------------------------------------------------------------
   rch_host_state_t state_reg;
   rch_cmd_t        kind_reg;
   logic [1:0]      area_reg;
   logic [7:0]      linkCnt_reg;
   logic [7:0]      busyLowCnt_reg;
   logic [7:0]      relCnt_reg;
   logic [7:0]      pulseCnt_reg;
   logic [7:0]      lineN_reg;
   logic            pulseEnd;
   logic            relEvent;
   logic            guardOk;
   logic [7:0]      clrTicks;

   // busy-fall and release counts start saturated so a first command is not held back needlessly
   function automatic logic [7:0] satInc(input logic [7:0] v, input logic tick);
      satInc = (tick && v != CNT_SAT) ? v + 8'h1 : v;
   endfunction

   assign pulseEnd = state_reg == HS_PULSE && msTick_reg && pulseCnt_reg == HOLD_TICKS - 8'h1;
   assign relEvent = pulseEnd && (kind_reg == RCH_SELECT || kind_reg == RCH_ADVANCE);
   assign clrTicks = modeSingleStep ? H_CLRS_TICKS : H_CLRM_TICKS;
   // every wait below is a least time, so one extra tick is counted
   assign guardOk = linkCnt_reg >= H_ARM_TICKS &&
      (kind_reg == RCH_CLEAR   ? busyLowCnt_reg >= clrTicks :
       kind_reg == RCH_SELECT  ? busyLowCnt_reg >= H_BSEL_TICKS :
       kind_reg == RCH_ADVANCE ? busyLowCnt_reg >= H_BADV_TICKS :
       relCnt_reg >= (modeSingleStep ? H_ADV_TICKS : H_SEL_TICKS));

   // since-link-rise, since-busy-fall and since-select-or-advance-release counts
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         linkCnt_reg    <= '0;
         busyLowCnt_reg <= CNT_SAT;
         relCnt_reg     <= CNT_SAT;
      end else begin
         linkCnt_reg    <= level_reg[0] ? satInc(linkCnt_reg, msTick_reg) : 8'h0;
         busyLowCnt_reg <= level_reg[1] ? 8'h0 : satInc(busyLowCnt_reg, msTick_reg);
         relCnt_reg     <= relEvent ? 8'h0 : satInc(relCnt_reg, msTick_reg);
      end
   end

   // ---------------------------------------------------------------
   // pulse sequencer
   // ---------------------------------------------------------------
   // select pulses lower the one line of the chosen area
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg    <= HS_IDLE;
         kind_reg     <= RCH_VERIFY;
         area_reg     <= '0;
         pulseCnt_reg <= '0;
         lineN_reg    <= PIN_IDLE;
         cmdReady     <= 1'b1;
      end else begin
         case (state_reg)
            HS_IDLE: begin
               if (cmdValid) begin
                  kind_reg  <= cmdKind;
                  area_reg  <= cmdArea;
                  cmdReady  <= 1'b0;
                  state_reg <= HS_GUARD;
               end
            end
            HS_GUARD: begin
               pulseCnt_reg <= '0;
               if (guardOk) begin
                  lineN_reg <= (kind_reg == RCH_SELECT) ?
                               ~(8'h20 << area_reg) : ~(8'h01 << kind_reg);
                  state_reg <= HS_PULSE;
               end
            end
            HS_PULSE: begin
               pulseCnt_reg <= satInc(pulseCnt_reg, msTick_reg);
               if (pulseEnd) begin
                  lineN_reg <= PIN_IDLE;
                  cmdReady  <= 1'b1;
                  state_reg <= HS_IDLE;
               end
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         linkSeen  <= 1'b0;
         busySeen  <= 1'b0;
         passSeen  <= 1'b0;
         errorSeen <= 1'b0;
      end else begin
         {errorSeen, passSeen, busySeen, linkSeen} <= level_reg;
      end
   end

   assign lnk.verify_cmd_in    = lineN_reg[0];
   assign lnk.startCmdN        = lineN_reg[1];
   assign lnk.enterCmdN        = lineN_reg[2];
   assign lnk.clearCmdN        = lineN_reg[3];
   assign lnk.advanceCmdN      = lineN_reg[4];
   assign lnk.area_select_in_0 = lineN_reg[5];
   assign lnk.area_select_in_1 = lineN_reg[6];
   assign lnk.area_select_in_2 = lineN_reg[7];

endmodule

// file: rtl/rch_if.sv
// wires of the remote command link between controller and device
// assumes both ends sit on their own copy of a 200 MHz clock
interface rch_if;
   logic link_ready_out;
   logic verify_cmd_in;
   logic startCmdN;
   logic enterCmdN;
   logic clearCmdN;
   logic advanceCmdN;
   logic area_select_in_0;
   logic area_select_in_1;
   logic area_select_in_2;
   logic busyOut;
   logic passOut;
   logic errorOut;

   modport devEnd (
      output link_ready_out, busyOut, passOut, errorOut,
      input  verify_cmd_in, startCmdN, enterCmdN, clearCmdN, advanceCmdN,
      input  area_select_in_0, area_select_in_1, area_select_in_2
   );

   modport hostEnd (
      input  link_ready_out, busyOut, passOut, errorOut,
      output verify_cmd_in, startCmdN, enterCmdN, clearCmdN, advanceCmdN,
      output area_select_in_0, area_select_in_1, area_select_in_2
   );
endinterface

// file: rtl/rch_pkg.sv
// constants and types shared by both ends of the remote command link
// assumes one 200 MHz clock per end and active-low command pins idling high
package rch_pkg;

   // ---------------------------------------------------------------
   // clock and millisecond timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned NS_PER_MS     = 1000000;
   localparam int unsigned CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned DIV_W         = 18;

   // ---------------------------------------------------------------
   // link timing, in milliseconds
   // ---------------------------------------------------------------
   localparam int unsigned CMD_MIN_MS          = 50;
   localparam int unsigned ARM_MS              = 1;
   localparam int unsigned SEL_TO_CMD_MS       = 1;
   localparam int unsigned BUSY_MAX_MULTI_MS   = 100;
   localparam int unsigned BUSY_TO_CLR_MULT_MS = 5;
   localparam int unsigned CLEAR_TO_RESULT_MS  = 50;
   localparam int unsigned BUSY_TO_SEL_MS      = 10;
   localparam int unsigned ADV_TO_CMD_MS       = 1;
   localparam int unsigned BUSY_MAX_AREA_MS    = 8000;
   localparam int unsigned BUSY_MAX_SAME_MS    = 50;
   localparam int unsigned BUSY_TO_CLR_SNGL_MS = 1;
   localparam int unsigned BUSY_TO_ADV_MS      = 1;

   // device side: accept after 49 ticks so clear and busy beat 50 ms
   localparam logic [5:0]  ACCEPT_TICKS   = 6'(CMD_MIN_MS - 1);
   localparam logic [1:0]  ARM_TICKS      = 2'(ARM_MS + 1);
   localparam int unsigned AREA_LOAD_MS   = 1000;
   localparam logic [12:0] AREA_LOAD_TICKS = 13'(AREA_LOAD_MS);
   localparam logic [1:0]  AREA_LAST      = 2'h2;

   // host side: a least time of n ms needs n+1 ticks of a free timebase
   localparam logic [7:0]  HOLD_TICKS     = 8'(CMD_MIN_MS + 1);
   localparam logic [7:0]  H_ARM_TICKS    = 8'(ARM_MS + 1);
   localparam logic [7:0]  H_SEL_TICKS    = 8'(SEL_TO_CMD_MS + 1);
   localparam logic [7:0]  H_ADV_TICKS    = 8'(ADV_TO_CMD_MS + 1);
   localparam logic [7:0]  H_CLRM_TICKS   = 8'(BUSY_TO_CLR_MULT_MS + 1);
   localparam logic [7:0]  H_CLRS_TICKS   = 8'(BUSY_TO_CLR_SNGL_MS + 1);
   localparam logic [7:0]  H_BSEL_TICKS   = 8'(BUSY_TO_SEL_MS + 1);
   localparam logic [7:0]  H_BADV_TICKS   = 8'(BUSY_TO_ADV_MS + 1);
   localparam logic [7:0]  CNT_SAT        = 8'hff;

   // ---------------------------------------------------------------
   // pin groups and reset values
   // ---------------------------------------------------------------
   // bit order: verify, start, enter, clear, advance, select 0..2
   localparam logic [7:0]  PIN_IDLE       = 8'hff;
   localparam logic [3:0]  HOST_IN_RST    = 4'h0;

   typedef enum logic [2:0] {
      RCH_VERIFY  = 3'h0,
      RCH_START   = 3'h1,
      RCH_ENTER   = 3'h2,
      RCH_CLEAR   = 3'h3,
      RCH_ADVANCE = 3'h4,
      RCH_SELECT  = 3'h5
   } rch_cmd_t;

   typedef enum logic [3:0] {
      DS_IDLE   = 4'b0001,
      DS_LOAD   = 4'b0010,
      DS_RUN    = 4'b0100,
      DS_RESULT = 4'b1000
   } rch_dev_state_t;

   typedef enum logic [2:0] {
      HS_IDLE  = 3'b001,
      HS_GUARD = 3'b010,
      HS_PULSE = 3'b100
   } rch_host_state_t;

endpackage

// file: verification/rch_link_props.sv
// checker for the remote command link, watching only the shared wires and the modeSingleStep input
// assumes the bench instantiates it beside the interface, one clock domain
module rch_link_props #(
   parameter int unsigned CYCLES_PER_MS = rch_pkg::CYCLES_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic modeSingleStep,
   input wire logic link_ready_out,
   input wire logic verify_cmd_in,
   input wire logic startCmdN,
   input wire logic enterCmdN,
   input wire logic clearCmdN,
   input wire logic advanceCmdN,
   input wire logic area_select_in_0,
   input wire logic area_select_in_1,
   input wire logic area_select_in_2,
   input wire logic busyOut,
   input wire logic passOut,
   input wire logic errorOut
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SAT = 1 << 30;
   // ----------------------------------------------------------------
   // helper counters, saturating so long idle spells never wrap
   // ----------------------------------------------------------------
   wire opsHigh = verify_cmd_in & startCmdN & enterCmdN;
   wire selHigh = area_select_in_0 & area_select_in_1 & area_select_in_2;
   wire allHigh = opsHigh & selHigh & clearCmdN & advanceCmdN;
   wire resHigh = passOut | errorOut;
   int  linkAge, opWait, clrWait, lowRun, busyIdle, selAge;
   logic areaChg;
   function automatic int inc(int x);
      return (x < SAT) ? x + 1 : x;
   endfunction
   // ages in cycles; busy and select ages start saturated like the host
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {linkAge, opWait, clrWait, lowRun} <= '0;
         busyIdle <= SAT;
         selAge <= SAT;
         areaChg <= 1'b0;
      end else begin
         linkAge <= link_ready_out ? inc(linkAge) : 0;
         opWait <= (!busyOut && (!opsHigh || opWait != 0)) ? inc(opWait) : 0;
         clrWait <= (resHigh && (!clearCmdN || clrWait != 0)) ? inc(clrWait) : 0;
         lowRun <= allHigh ? 0 : inc(lowRun);
         busyIdle <= busyOut ? 0 : inc(busyIdle);
         selAge <= $fell(selHigh & advanceCmdN) ? 0 : inc(selAge);
         areaChg <= $fell(advanceCmdN) || (areaChg && !busyOut); // reload until busy
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_busyUp;
      $rose(busyOut);
   endsequence
   property p_armGap; s_busyUp |-> linkAge > CYCLES_PER_MS; endproperty
   property p_opBusy;
      opWait <= (!modeSingleStep ? 100 : (areaChg ? 8000 : 50)) * CYCLES_PER_MS;
   endproperty
   property p_clrDrop; clrWait <= 50 * CYCLES_PER_MS; endproperty
   property p_filter; s_busyUp ##0 !modeSingleStep |-> lowRun >= 48 * CYCLES_PER_MS; endproperty
   property p_holdWidth; $rose(allHigh) |-> lowRun >= 50 * CYCLES_PER_MS; endproperty
   property p_clrGap;
      $fell(clearCmdN) |-> busyIdle >= (modeSingleStep ? 1 : 5) * CYCLES_PER_MS;
   endproperty
   property p_selGap; $fell(selHigh) |-> busyIdle >= 10 * CYCLES_PER_MS; endproperty
   property p_advGap; $fell(advanceCmdN) |-> busyIdle >= CYCLES_PER_MS; endproperty
   property p_opGap; $fell(verify_cmd_in & startCmdN) |-> selAge >= CYCLES_PER_MS; endproperty
   a_armGap: assert property (p_armGap)
      else $error("busy rose before link armed");
   a_opBusy: assert property (p_opBusy)
      else $error("busy late after op");
   a_clrDrop: assert property (p_clrDrop)
      else $error("result late to drop");
   a_filter: assert property (p_filter)
      else $error("busy after short pulse");
   a_holdWidth: assert property (p_holdWidth)
      else $error("command pulse too short");
   a_clrGap: assert property (p_clrGap)
      else $error("clear too soon after busy");
   a_selGap: assert property (p_selGap)
      else $error("select too soon after busy");
   a_advGap: assert property (p_advGap)
      else $error("advance too soon after busy");
   a_opGap: assert property (p_opGap)
      else $error("op too soon after select");
endmodule

// file: verification/remote_control_handshake_test.sv
// self-checking bench: host end drives device end over the shared link
// assumes a 200 MHz clock; the millisecond is shortened to 20 cycles
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH at %0t: value differs", $time); end end
module remote_control_handshake_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rch_pkg::*;
   localparam int CPM = 20;
   logic       clk_sys = 0, rst = 1, linkEnable = 0, mode = 0, opDone = 0, opPass = 0;
   logic       cmdValid = 0, opStart, linkArmed, cmdReady, linkSeen;
   logic       busySeen, passSeen, errorSeen;
   logic [1:0] cmdArea = 0, opArea, a;
   rch_cmd_t   cmdKind = RCH_VERIFY, opKind;
   int         n_mismatch = 0, check_count = 0, seed = 96, cyc = 0, lastWait;
   rch_if lnk();
   rch_device #(.CYCLES_PER_MS(CPM)) u_rch_device (.clk_sys(clk_sys), .rst(rst), .lnk(lnk),
      .linkEnable(linkEnable), .modeSingleStep(mode), .opDone(opDone), .opPass(opPass),
      .opStart(opStart), .opKind(opKind), .opArea(opArea), .linkArmed(linkArmed));
   rch_host #(.CYCLES_PER_MS(CPM)) u_rch_host (.clk_sys(clk_sys), .rst(rst), .lnk(lnk),
      .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdArea(cmdArea), .modeSingleStep(mode),
      .cmdReady(cmdReady), .linkSeen(linkSeen), .busySeen(busySeen), .passSeen(passSeen),
      .errorSeen(errorSeen));
   rch_link_props #(.CYCLES_PER_MS(CPM)) u_props (.clk_sys(clk_sys), .rst(rst),
      .modeSingleStep(mode), .link_ready_out(lnk.link_ready_out),
      .verify_cmd_in(lnk.verify_cmd_in), .startCmdN(lnk.startCmdN), .enterCmdN(lnk.enterCmdN),
      .clearCmdN(lnk.clearCmdN), .advanceCmdN(lnk.advanceCmdN),
      .area_select_in_0(lnk.area_select_in_0), .area_select_in_1(lnk.area_select_in_1),
      .area_select_in_2(lnk.area_select_in_2), .busyOut(lnk.busyOut),
      .passOut(lnk.passOut), .errorOut(lnk.errorOut));
   // ----------------------------------------------------------------
   // clock, hang guard and verdict
   // ----------------------------------------------------------------
   initial forever #2.5 clk_sys = ~clk_sys;
   // the slow area reload dominates the run, about 36k cycles in all
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // drivers: inputs move on falling edges only
   // ----------------------------------------------------------------
   task automatic tick(int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic await(ref logic s, input logic v, input int lim);
      lastWait = 0;
      while (s !== v && lastWait < lim) begin
         tick(1);
         lastWait++;
      end
      `CHK(lastWait < lim, 1'b1)
   endtask
   task automatic send(rch_cmd_t k, logic [1:0] ar);
      await(cmdReady, 1'b1, 4000);
      cmdKind = k;
      cmdArea = ar;
      cmdValid = 1;
      tick(1);
      cmdValid = 0;
   endtask
   function automatic logic [1:0] next_area(logic [1:0] x);
      return (x == 2'h2) ? 2'h0 : x + 2'h1;
   endfunction
   // one operation: answer, random verdict, then clear the result
   task automatic run_op(rch_cmd_t k, logic [1:0] ar, int lim);
      logic p;
      p = 1'($random(seed));
      send(k, 2'h0);
      await(opStart, 1'b1, lim);
      `CHK(opKind, k)
      `CHK(opArea, ar)
      `CHK(lnk.busyOut, 1'b1)
      `CHK(linkArmed, 1'b1)
      tick(3 * CPM + ($random(seed) & 255));
      opPass = p;
      opDone = 1;
      tick(1);
      opDone = 0;
      tick(6);
      `CHK({lnk.busyOut, lnk.passOut, lnk.errorOut}, {1'b0, p, !p})
      `CHK({busySeen, passSeen, errorSeen}, {1'b0, p, !p})
      send(RCH_CLEAR, 2'h0);
      if (p) await(lnk.passOut, 1'b0, 60 * CPM);
      else await(lnk.errorOut, 1'b0, 60 * CPM);
      `CHK({lnk.passOut, lnk.errorOut}, 2'b00)
   endtask
   initial begin
      tick(4);
      rst = 0;
      linkEnable = 1;
      await(linkSeen, 1'b1, 50);
      `CHK(lnk.link_ready_out, 1'b1)
      `CHK(linkArmed, 1'b0)
      // every operation code, each on a random area
      for (int i = 0; i < 3; i++) begin
         a = 2'($unsigned($random(seed)) % 3);
         send(RCH_SELECT, a);
         run_op(rch_cmd_t'(i), a, 60 * CPM);
      end
      mode = 1;
      send(RCH_ADVANCE, 2'h0);
      run_op(RCH_START, next_area(a), 1100 * CPM);
      run_op(RCH_ENTER, next_area(a), 52 * CPM);
      finish_test();
   end
endmodule
